// ==== include/pulse_profile_pkg.sv ====
// constants, register map and state types for the pulse profile engine
// assumes a 20 MHz clk_sys and a byte-wide data memory read port
package pulse_profile_pkg;
	// clock and time base
	localparam int unsigned CLK_HZ        = 20000000;
	localparam int unsigned TICK_US_NS    = 1000;
	localparam int unsigned TICK_MS_NS    = 1000000;
	localparam int unsigned CLK_NS        = 1000000000 / CLK_HZ;
	localparam int unsigned US_CYCLES     = TICK_US_NS / CLK_NS;
	localparam int unsigned MS_CYCLES     = TICK_MS_NS / CLK_NS;

	// profile table layout
	localparam int unsigned SEG_MAX       = 255;
	localparam int unsigned SEG_BYTES     = 8;
	localparam logic [15:0] MIN_PERIOD    = 16'h0002;

	// register byte addresses (word aligned)
	localparam logic [3:0] ADDR_CTRL      = 4'h0;
	localparam logic [3:0] ADDR_STATUS    = 4'h4;
	localparam logic [3:0] ADDR_TABLE     = 4'h8;
	localparam logic [3:0] ADDR_SEGMENT   = 4'hc;

	// control fields
	localparam int unsigned CTRL_TB_BIT   = 3;
	localparam int unsigned CTRL_MULTI_BIT = 5;
	localparam int unsigned CTRL_EN_BIT   = 7;
	localparam logic [7:0]  CTRL_RESET    = 8'h00;

	// status fields
	localparam int unsigned ST_DERR_BIT   = 4;
	localparam int unsigned ST_ABORT_BIT  = 5;
	localparam int unsigned ST_IDLE_BIT   = 7;
	localparam logic [15:0] TABLE_RESET   = 16'h0000;

	typedef enum logic [5:0] {
		S_IDLE  = 6'b000001,
		S_COUNT = 6'b000010,
		S_FETCH = 6'b000100,
		S_WAIT  = 6'b001000,
		S_LOAD  = 6'b010000,
		S_RUN   = 6'b100000
	} state_t;
endpackage : pulse_profile_pkg

// ==== rtl/tick_divider.sv ====
// time base divider: one-cycle tick every microsecond or millisecond
// assumes clk_sys at the package rate
`timescale 1ns/1ps
module tick_divider
	import pulse_profile_pkg::*;
(
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rstn,
	// control
	input  wire logic run,
	input  wire logic ms_sel,
	// tick out
	output logic      tick
);
	localparam logic [15:0] US_LAST = 16'(US_CYCLES - 1);
	localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

	logic [15:0] cnt_q;

	// free count restarted while stopped so the first tick is a full unit
	always_ff @(posedge clk_sys) begin
		if (!rstn || !run || tick) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	assign tick = run && (cnt_q == (ms_sel ? MS_LAST : US_LAST));
endmodule : tick_divider

// ==== rtl/pulse_profile.sv ====
// multi-segment pulse train engine with avalon-mm registers and a memory read port
// assumes a byte memory answering mem_rvalid one or more cycles after mem_read
`timescale 1ns/1ps
module pulse_profile
	import pulse_profile_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// data memory read port
	output logic [15:0]      mem_addr,
	output logic             mem_read,
	input  wire logic [7:0]  mem_rdata,
	input  wire logic        mem_rvalid,
	// pulse output and image fallback
	input  wire logic        image_out,
	output logic             pulse_train_output
);
	typedef struct packed {
		state_t      st;
		logic [7:0]  ctrl;
		logic [15:0] table_base;
		logic        derr;
		logic        uabort;
		logic [7:0]  seg_total;
		logic [7:0]  seg_num;
		logic [2:0]  byte_idx;
		logic [63:0] seg_buf;
		logic [15:0] addr;
		logic [15:0] period;
		logic signed [15:0] delta;
		logic [31:0] pulses_left;
		logic [15:0] tick_cnt;
		logic        pin;
		logic        ack;
		logic [31:0] rdata;
	} regs_t;

	regs_t r_q, r_d;
	logic  tick;

	// register decode used by both read and write paths
	function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
		return a == off;
	endfunction : hit

	tick_divider u_tick (
		.clk_sys (clk_sys),
		.rstn    (rstn),
		.run     (r_q.st == S_RUN),
		.ms_sel  (r_q.ctrl[CTRL_TB_BIT]),
		.tick    (tick)
	);

	// one cycle wait then answer; ack drops waitrequest for exactly one cycle
	// a write commits on the waiting edge; harmless since the master holds it
	assign avs_waitrequest    = (avs_read || avs_write) && !r_q.ack;
	assign avs_readdata       = r_q.rdata;
	// fetch strobe is a state decode, so it holds until the memory answers
	assign mem_addr           = r_q.addr;
	assign mem_read           = (r_q.st == S_COUNT || r_q.st == S_FETCH);
	// outside a profile the pin follows the image bit
	assign pulse_train_output = (r_q.st == S_RUN) ? r_q.pin : image_out;

	// next-state logic for bus, fetch and pulse generation
	always_comb begin
		logic bus_req;
		logic en_fall;
		logic [16:0] nxt;
		logic [15:0] half;
		bus_req = 1'b0;
		en_fall = 1'b0;
		nxt     = 17'h00000;
		half    = 16'h0000;
		r_d     = r_q;
		r_d.ack = 1'b0;
		bus_req = (avs_read || avs_write) && !r_q.ack;

		// bus access; status flags are write-one-to-clear
		// a clear here loses to a hardware set further down in the same cycle
		if (bus_req) begin
			r_d.ack = 1'b1;
			r_d.rdata = 32'h00000000;
			if (avs_read) begin
				if (hit(avs_address, ADDR_CTRL)) begin
					r_d.rdata = {24'h000000, r_q.ctrl};
				end else if (hit(avs_address, ADDR_STATUS)) begin
					r_d.rdata[ST_IDLE_BIT]  = (r_q.st == S_IDLE);
					r_d.rdata[ST_ABORT_BIT] = r_q.uabort;
					r_d.rdata[ST_DERR_BIT]  = r_q.derr;
				end else if (hit(avs_address, ADDR_TABLE)) begin
					r_d.rdata = {16'h0000, r_q.table_base};
				end else if (hit(avs_address, ADDR_SEGMENT)) begin
					r_d.rdata = {24'h000000, r_q.seg_num};
				end
			end else begin
				if (hit(avs_address, ADDR_CTRL)) begin
					r_d.ctrl = avs_writedata[7:0];
					en_fall  = r_q.ctrl[CTRL_EN_BIT] && !avs_writedata[CTRL_EN_BIT];
				end else if (hit(avs_address, ADDR_STATUS)) begin
					if (avs_writedata[ST_DERR_BIT]) r_d.derr = 1'b0;
					if (avs_writedata[ST_ABORT_BIT]) r_d.uabort = 1'b0;
				end else if (hit(avs_address, ADDR_TABLE)) begin
					r_d.table_base = avs_writedata[15:0];
				end
			end
		end

		unique case (r_q.st)
			S_IDLE: begin
				// a rising enable in multi mode launches the profile
				if (bus_req && avs_write && hit(avs_address, ADDR_CTRL) &&
				    avs_writedata[CTRL_EN_BIT] && avs_writedata[CTRL_MULTI_BIT] &&
				    !r_q.ctrl[CTRL_EN_BIT]) begin
					r_d.st   = S_COUNT;
					r_d.addr = r_q.table_base;
				end
			end
			// an empty table ends at once and never touches the pin
			S_COUNT: if (mem_rvalid) begin
				r_d.seg_total = mem_rdata;
				r_d.seg_num   = 8'h00;
				r_d.addr      = r_q.addr + 16'h0001;
				r_d.byte_idx  = 3'h0;
				r_d.st        = (mem_rdata == 8'h00) ? S_IDLE : S_FETCH;
			end
			S_FETCH: if (mem_rvalid) begin
				// bytes land low first; words and dword are little endian
				r_d.seg_buf  = {mem_rdata, r_q.seg_buf[63:8]};
				r_d.addr     = r_q.addr + 16'h0001;
				r_d.byte_idx = r_q.byte_idx + 3'h1;
				if (r_q.byte_idx == 3'(SEG_BYTES - 1)) r_d.st = S_LOAD;
			end
			S_LOAD: begin
				// each segment restarts from its own start period
				// a zero count or a start period below the minimum cannot be run
				r_d.period      = r_q.seg_buf[15:0];
				r_d.delta       = r_q.seg_buf[31:16];
				r_d.pulses_left = r_q.seg_buf[63:32];
				r_d.seg_num     = r_q.seg_num + 8'h01;
				r_d.tick_cnt    = 16'h0000;
				r_d.pin         = 1'b1;
				if (r_q.seg_buf[15:0] < MIN_PERIOD || r_q.seg_buf[63:32] == 32'h0) begin
					r_d.derr = 1'b1;
					r_d.st   = S_IDLE;
				end else begin
					r_d.st = S_RUN;
				end
			end
			S_RUN: begin
				// 50 percent duty for even periods: high for half the period rounded down, low for the rest
				half = {1'b0, r_q.period[15:1]};
				if (tick) begin
					if (r_q.tick_cnt + 16'h0001 == half) r_d.pin = 1'b0;
					if (r_q.tick_cnt + 16'h0001 == r_q.period) begin
						r_d.tick_cnt    = 16'h0000;
						r_d.pin         = 1'b1;
						r_d.pulses_left = r_q.pulses_left - 32'h1;
						// period stepped once per pulse, so last = start+delta*(n-1)
						nxt = {1'b0, r_q.period} + {{1{r_q.delta[15]}}, r_q.delta};
						r_d.period = nxt[15:0];
						// the last pulse skips the range check: its successor is never used
						if (r_q.pulses_left == 32'h1) begin
							r_d.pin = 1'b0;
							// next segment in table order or finish
							r_d.st = (r_q.seg_num == r_q.seg_total) ? S_IDLE : S_FETCH;
							r_d.byte_idx = 3'h0;
						end else if (nxt[16] || nxt[15:0] < MIN_PERIOD) begin
							r_d.derr = 1'b1;
							r_d.st   = S_IDLE;
						end
					end else begin
						r_d.tick_cnt = r_q.tick_cnt + 16'h0001;
					end
				end
			end
			default: r_d.st = S_IDLE;
		endcase

		// disable wins over any progress this cycle
		// enable stays set after a finished profile; software clears it to relaunch
		if (en_fall && r_q.st != S_IDLE) begin
			r_d.uabort = 1'b1;
			r_d.st     = S_IDLE;
		end
	end

	// single register stage for the whole state
	// reset is synchronous, so only constants appear in this branch
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			r_q            <= '0;
			r_q.st         <= S_IDLE;
			r_q.ctrl       <= CTRL_RESET;
			r_q.table_base <= TABLE_RESET;
		end else begin
			r_q <= r_d;
		end
	end
endmodule : pulse_profile

// ==== tb/pp_monitor.sv ====
// port checks for the pulse profile engine
// assumes a bind onto pulse_profile, one clock domain
`timescale 1ns/1ps
module pp_monitor (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rstn,
	// register bus
	input wire logic [3:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// memory port and pin
	input wire logic [15:0] mem_addr,
	input wire logic        mem_read,
	input wire logic [7:0]  mem_rdata,
	input wire logic        mem_rvalid,
	input wire logic        image_out,
	input wire logic        pulse_train_output
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	wire req = avs_read | avs_write;

	// one wait state, then the answer
	one_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	no_wait_a: assert property (!req |-> !avs_waitrequest)
		else $error("wait raised without request");
	rdata_hold_a: assert property (!req |-> $stable(avs_readdata))
		else $error("read data moved while idle");
	// fetches hold their address and step one byte per answer
	mem_hold_a: assert property (mem_read && !mem_rvalid |=> mem_read && $stable(mem_addr))
		else $error("fetch dropped before answer");
	addr_step_a: assert property (mem_read && mem_rvalid |=> !mem_read ||
		mem_addr == $past(mem_addr) + 16'h1) else $error("fetch address skipped");
	pin_fetch_a: assert property (mem_read |-> pulse_train_output == image_out)
		else $error("pin not under image while fetching");
	// every half period lasts more than eight cycles
	high_min_a: assert property ($rose(pulse_train_output) |=> pulse_train_output[*8])
		else $error("pulse high too short");
	low_min_a: assert property ($fell(pulse_train_output) |=> !pulse_train_output[*8])
		else $error("pulse low too short");
endmodule : pp_monitor

// ==== tb/profile_mem.sv ====
// byte-wide data memory model answering the engine's fetch port
// assumes the bench fills m and sets lat before a launch
`timescale 1ns/1ps
module profile_mem (
	// clock
	input wire logic        clk_sys,
	// fetch port
	input wire logic [15:0] mem_addr,
	input wire logic        mem_read,
	output logic [7:0]      mem_rdata,
	output logic            mem_rvalid,
	// extra answer delay in cycles beyond the minimum one
	input wire logic [1:0]  lat
);
	logic [7:0] m [0:255];
	logic [1:0] n = 2'h0;
	initial mem_rvalid = 1'b0;
	initial mem_rdata = 8'h00;
	// answer lat+1 cycles after the read; stale data is inverted so it never looks valid
	always @(posedge clk_sys) begin
		n <= (mem_read && !mem_rvalid && n != lat) ? n + 2'h1 : 2'h0;
		mem_rvalid <= mem_read && !mem_rvalid && n == lat;
		mem_rdata <= (mem_read && !mem_rvalid && n == lat) ? m[mem_addr[7:0]] : ~mem_rdata;
	end
endmodule : profile_mem

// ==== tb/tb.sv ====
// self-checking bench for the pulse profile engine
// assumes package, engine, memory model and monitor compiled first
`timescale 1ns/1ps
module tb;
	import pulse_profile_pkg::*;
	logic        clk_sys, rstn, avs_read, avs_write, image_out, mem_rvalid, mem_read;
	logic        avs_waitrequest, pulse_train_output;
	logic        pin_q = 1'b0;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [15:0] mem_addr;
	logic [7:0]  mem_rdata;
	logic [1:0]  lat;
	int          n_fail, checks, cyc;
	int          rise[$], fall[$];
	pulse_profile dut (.clk_sys, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .mem_addr, .mem_read, .mem_rdata, .mem_rvalid,
		.image_out, .pulse_train_output);
	profile_mem mem (.clk_sys, .mem_addr, .mem_read, .mem_rdata, .mem_rvalid, .lat);

	// clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// cycle count and pin edge log
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		pin_q <= pulse_train_output;
		if (pulse_train_output && !pin_q) rise.push_back(cyc);
		if (!pulse_train_output && pin_q) fall.push_back(cyc);
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one bus access; held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_sys);
	endtask : bus
	task automatic idle_wait;
		do bus(0, ADDR_STATUS, 0); while (rd[ST_IDLE_BIT] !== 1'b1);
	endtask : idle_wait
	task automatic seg(input int a, input logic [63:0] v);
		for (int i = 0; i < 8; i++) mem.m[a + i] = v[8*i +: 8];
	endtask : seg
	task automatic t_regs;
		bus(0, ADDR_CTRL, 0);
		chk("ctrl", rd, {24'h0, CTRL_RESET});
		bus(0, ADDR_TABLE, 0);
		chk("table", rd, {16'h0, TABLE_RESET});
		bus(0, ADDR_STATUS, 0);
		chk("idle", rd[ST_IDLE_BIT], 1);
		bus(1, 4'h2, 32'hffffffff);
		bus(0, 4'h2, 0);
		chk("unmapped", rd, 0);
		image_out <= 1'b1;
		repeat (12) @(posedge clk_sys);
		chk("image pin", pulse_train_output, 1);
		image_out <= 1'b0;
	endtask : t_regs
	// two segments: 4 up by 2 for 3 pulses, then 4 down by 1 for 2
	task automatic t_run;
		mem.m[16] = 8'h02;
		seg(17, {32'h3, 16'h0002, 16'h0004});
		seg(25, {32'h2, 16'hffff, 16'h0004});
		bus(1, ADDR_TABLE, 32'h10);
		rise.delete();
		fall.delete();
		bus(1, ADDR_CTRL, 32'ha0);
		while (rise.size() < 4) @(posedge clk_sys);
		bus(0, ADDR_SEGMENT, 0);
		chk("segment", rd, 2);
		idle_wait();
		chk("pulses", rise.size(), 5);
		chk("period 1", rise[1] - rise[0], 4 * US_CYCLES);
		chk("period 2", rise[2] - rise[1], 6 * US_CYCLES);
		chk("last high", fall[2] - rise[2], 4 * US_CYCLES);
		chk("duration", rise[2] - rise[0] + 2 * (fall[2] - rise[2]), 18 * US_CYCLES);
		chk("seg2 start", rise[4] - rise[3], 4 * US_CYCLES);
		chk("seg2 high", fall[4] - rise[4], 1 * US_CYCLES);
	endtask : t_run
	// period 3 minus 2 gives 1, which is illegal
	task automatic t_err;
		lat <= 2'h2;
		mem.m[48] = 8'h01;
		seg(49, {32'h3, 16'hfffe, 16'h0003});
		bus(1, ADDR_TABLE, 32'h30);
		rise.delete();
		// enable is still set from the last profile; a launch needs a fresh rising enable
		bus(1, ADDR_CTRL, 0);
		bus(1, ADDR_CTRL, 32'ha0);
		idle_wait();
		chk("delta error", rd[ST_DERR_BIT], 1);
		chk("error pulses", rise.size(), 1);
		bus(1, ADDR_STATUS, 32'(1) << ST_DERR_BIT);
		bus(0, ADDR_STATUS, 0);
		chk("error cleared", rd[ST_DERR_BIT], 0);
	endtask : t_err
	// long millisecond segment disabled mid-pulse
	task automatic t_abort;
		mem.m[64] = 8'h01;
		seg(65, {32'd1000, 16'h0000, 16'h0004});
		bus(1, ADDR_TABLE, 32'h40);
		// single-segment mode is not served here: enable alone must not launch
		bus(1, ADDR_CTRL, 0);
		bus(1, ADDR_CTRL, 32'h80);
		bus(0, ADDR_STATUS, 0);
		chk("single mode idle", rd[ST_IDLE_BIT], 1);
		bus(1, ADDR_CTRL, 0);
		rise.delete();
		fall.delete();
		bus(1, ADDR_CTRL, 32'ha8);
		// a microsecond base would have dropped the pin well inside this wait
		repeat (300) @(posedge clk_sys);
		chk("ms pin", pulse_train_output, 1);
		chk("ms no fall", fall.size(), 0);
		bus(1, ADDR_CTRL, 0);
		idle_wait();
		chk("user abort", rd[ST_ABORT_BIT], 1);
		chk("abort pin", pulse_train_output, 0);
	endtask : t_abort
	task automatic conclude;
		if (n_fail == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude
	// watchdog
	initial begin
		repeat (30000) @(posedge clk_sys);
		n_fail++;
		conclude();
	end
	initial begin
		{rstn, avs_read, avs_write, image_out, avs_address, avs_writedata, lat} = '0;
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		t_regs();
		t_run();
		t_err();
		t_abort();
		conclude();
	end
endmodule : tb
bind pulse_profile pp_monitor mon (.clk_sys, .rstn, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_readdata, .avs_waitrequest, .mem_addr, .mem_read, .mem_rdata,
	.mem_rvalid, .image_out, .pulse_train_output);
